// >>> design/ifc_pkg.sv
package ifc_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LEVEL_W = 5;
   localparam int TRIG_W = 4;
   localparam int NUM_OVR = 2;

   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_BITS = 8'h3C;
   localparam logic [ADDR_W-1:0] OFS_RX_OVERRUN_CLEAR = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_TX_OVERRUN_CLEAR = 8'h44;
   localparam logic [ADDR_W-1:0] OFS_RX_FIFO_TRIGGER_LEVEL = 8'h48;

   localparam int BIT_RX_AVAIL = 0;
   localparam int BIT_RX_OVERRUN = 1;
   localparam int BIT_TX_OVERRUN = 5;
   localparam int BIT_OVERRUN_FLAG = 0;

   localparam int OVR_RX = 0;
   localparam int OVR_TX = 1;

   localparam logic [DATA_W-1:0] IRQ_BITS_USED = 32'h0000_0023;
   localparam logic [DATA_W-1:0] IRQ_MASK_RST = 32'h0000_0023;
   localparam logic [TRIG_W-1:0] RX_TRIGGER_RST = 4'h3;
   localparam logic OVERRUN_FLAG_RST = 1'b1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic rx_wr;
      logic rx_full;
      logic tx_wr;
      logic tx_full;
      logic [LEVEL_W-1:0] rx_level;
   } ifc_fifo_evt_t;

   typedef enum logic [1:0] {
      IFC_APB_IDLE = 2'b00,
      IFC_APB_SETUP = 2'b01,
      IFC_APB_ACCESS = 2'b10
   } ifc_apb_phase_t;

endpackage : ifc_pkg

// >>> design/ifc_sticky_flag.sv
`timescale 1ns/100ps
module ifc_sticky_flag #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set,
   input wire logic clr,
   output logic flag
);

   logic flag_ff;
   logic nxt_flag;

   // A set arriving together with a clear keeps the flag, so no event is lost.
   always_comb begin
      nxt_flag = flag_ff;
      if (clr) begin
         nxt_flag = 1'b0;
      end
      if (set) begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_ff <= RST_VAL;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;

endmodule : ifc_sticky_flag

// >>> design/ifc_irq_ctrl.sv
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module ifc_irq_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ifc_pkg::ADDR_W-1:0] paddr,
   input wire logic [ifc_pkg::DATA_W-1:0] pwdata,
   output logic [ifc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ifc_pkg::ifc_fifo_evt_t fifo_evt,
   output logic [ifc_pkg::TRIG_W-1:0] rx_trigger_level,
   output logic irq
);

   // Bus phase tracking.
   ifc_pkg::ifc_apb_phase_t phase_ff;
   ifc_pkg::ifc_apb_phase_t nxt_phase;

   // Register file state.
   logic [ifc_pkg::DATA_W-1:0] irq_mask_bits_ff;
   logic [ifc_pkg::DATA_W-1:0] nxt_irq_mask_bits;
   logic [ifc_pkg::TRIG_W-1:0] rx_trigger_field_ff;
   logic [ifc_pkg::TRIG_W-1:0] nxt_rx_trigger_field;
   logic rx_avail_status_ff;
   logic nxt_rx_avail_status;
   logic irq_ff;
   logic nxt_irq;
   logic [ifc_pkg::DATA_W-1:0] prdata_ff;
   logic [ifc_pkg::DATA_W-1:0] nxt_prdata;

   // Decode and access strobes.
   logic setup_rd;
   logic access;
   logic wr_en;
   logic rd_en;
   logic addr_hit;
   logic sel_status;
   logic sel_mask;
   logic sel_rx_ovr;
   logic sel_tx_ovr;
   logic sel_trig;
   logic setup_seen;

   // Overrun events and flags.
   logic [ifc_pkg::NUM_OVR-1:0] ovr_set;
   logic [ifc_pkg::NUM_OVR-1:0] ovr_clr;
   logic [ifc_pkg::NUM_OVR-1:0] ovr_flag;
   logic [ifc_pkg::NUM_OVR-1:0] ovr_view;
   logic [ifc_pkg::DATA_W-1:0] status_word;
   logic [ifc_pkg::DATA_W-1:0] read_word;
   logic [ifc_pkg::DATA_W-1:0] status_next_word;
   logic [ifc_pkg::DATA_W-1:0] pend_bits;
   logic [ifc_pkg::NUM_OVR-1:0] rd_clr;
   logic [ifc_pkg::NUM_OVR-1:0] w1c_clr;

   // One select per mapped register; every other address leaves all selects low.
   always_comb begin
      sel_status = 1'b0;
      sel_mask = 1'b0;
      sel_rx_ovr = 1'b0;
      sel_tx_ovr = 1'b0;
      sel_trig = 1'b0;
      unique case (paddr)
         ifc_pkg::OFS_IRQ_STATUS: begin
            sel_status = 1'b1;
         end
         ifc_pkg::OFS_IRQ_MASK_BITS: begin
            sel_mask = 1'b1;
         end
         ifc_pkg::OFS_RX_OVERRUN_CLEAR: begin
            sel_rx_ovr = 1'b1;
         end
         ifc_pkg::OFS_TX_OVERRUN_CLEAR: begin
            sel_tx_ovr = 1'b1;
         end
         ifc_pkg::OFS_RX_FIFO_TRIGGER_LEVEL: begin
            sel_trig = 1'b1;
         end
         default: begin
            sel_status = 1'b0;
         end
      endcase
   end

   assign addr_hit = sel_status | sel_mask | sel_rx_ovr | sel_tx_ovr | sel_trig;

   assign setup_rd = psel & ~penable & ~pwrite;
   // An access phase counts only right after its setup phase, so a stray penable
   // without a setup cycle neither writes nor clears anything.
   assign setup_seen = (phase_ff == ifc_pkg::IFC_APB_SETUP);
   assign access = psel & penable & setup_seen;
   assign wr_en = access & pwrite & addr_hit;
   assign rd_en = access & ~pwrite & addr_hit;

   // The slave never inserts wait states; unmapped addresses answer with an error.
   assign pready = 1'b1;
   assign pslverr = access & ~addr_hit;

   // Overrun means a write was attempted while the FIFO was already full.
   assign ovr_set[ifc_pkg::OVR_RX] = fifo_evt.rx_wr & fifo_evt.rx_full;
   assign ovr_set[ifc_pkg::OVR_TX] = fifo_evt.tx_wr & fifo_evt.tx_full;

   // Reads of the dedicated overrun registers clear their flag; writing a one to the
   // matching status bit clears it as well.
   assign rd_clr[ifc_pkg::OVR_RX] = rd_en & sel_rx_ovr;
   assign rd_clr[ifc_pkg::OVR_TX] = rd_en & sel_tx_ovr;
   assign w1c_clr[ifc_pkg::OVR_RX] = wr_en & sel_status & pwdata[ifc_pkg::BIT_RX_OVERRUN];
   assign w1c_clr[ifc_pkg::OVR_TX] = wr_en & sel_status & pwdata[ifc_pkg::BIT_TX_OVERRUN];
   assign ovr_clr = rd_clr | w1c_clr;

   genvar gi;
   generate
      for (gi = 0; gi < ifc_pkg::NUM_OVR; gi++) begin : g_ovr
         ifc_sticky_flag #(
            .RST_VAL(ifc_pkg::OVERRUN_FLAG_RST)
         ) u_flag (
            .pclk(pclk),
            .presetn(presetn),
            .set(ovr_set[gi]),
            .clr(ovr_clr[gi]),
            .flag(ovr_flag[gi])
         );
         // A read sampled in setup already sees an event landing that same edge.
         assign ovr_view[gi] = ovr_flag[gi] | ovr_set[gi];
      end
   endgenerate

   always_comb begin
      status_word = ifc_pkg::DATA_ZERO;
      status_word[ifc_pkg::BIT_RX_AVAIL] = rx_avail_status_ff;
      status_word[ifc_pkg::BIT_RX_OVERRUN] = ovr_flag[ifc_pkg::OVR_RX];
      status_word[ifc_pkg::BIT_TX_OVERRUN] = ovr_flag[ifc_pkg::OVR_TX];
   end

   always_comb begin
      status_next_word = status_word;
      status_next_word[ifc_pkg::BIT_RX_OVERRUN] = ovr_view[ifc_pkg::OVR_RX];
      status_next_word[ifc_pkg::BIT_TX_OVERRUN] = ovr_view[ifc_pkg::OVR_TX];
   end

   // Unmapped addresses and unused bits read as zero.
   always_comb begin
      read_word = ifc_pkg::DATA_ZERO;
      unique case (paddr)
         ifc_pkg::OFS_IRQ_STATUS: begin
            read_word = status_next_word;
         end
         ifc_pkg::OFS_IRQ_MASK_BITS: begin
            read_word = irq_mask_bits_ff;
         end
         ifc_pkg::OFS_RX_OVERRUN_CLEAR: begin
            read_word[ifc_pkg::BIT_OVERRUN_FLAG] = ovr_view[ifc_pkg::OVR_RX];
         end
         ifc_pkg::OFS_TX_OVERRUN_CLEAR: begin
            read_word[ifc_pkg::BIT_OVERRUN_FLAG] = ovr_view[ifc_pkg::OVR_TX];
         end
         ifc_pkg::OFS_RX_FIFO_TRIGGER_LEVEL: begin
            read_word[ifc_pkg::TRIG_W-1:0] = rx_trigger_field_ff;
         end
         default: begin
            read_word = ifc_pkg::DATA_ZERO;
         end
      endcase
   end

   // Bus phase, used to qualify the access phase.
   always_comb begin
      nxt_phase = ifc_pkg::IFC_APB_IDLE;
      if (psel && !penable) begin
         nxt_phase = ifc_pkg::IFC_APB_SETUP;
      end else if (psel && penable) begin
         nxt_phase = ifc_pkg::IFC_APB_ACCESS;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= ifc_pkg::IFC_APB_IDLE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // Read data is captured at the setup edge and stands through the access phase.
   // The read-to-clear acts one edge later, so the flag shown is never lost.
   always_comb begin
      nxt_prdata = prdata_ff;
      if (setup_rd) begin
         nxt_prdata = read_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= ifc_pkg::DATA_ZERO;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   // Interrupt mask, one bit per status bit; a one masks. Unbuilt bits stay zero.
   always_comb begin
      nxt_irq_mask_bits = irq_mask_bits_ff;
      if (wr_en && sel_mask) begin
         nxt_irq_mask_bits = pwdata & ifc_pkg::IRQ_BITS_USED;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_bits_ff <= ifc_pkg::IRQ_MASK_RST;
      end else begin
         irq_mask_bits_ff <= nxt_irq_mask_bits;
      end
   end

   // Receive trigger level.
   always_comb begin
      nxt_rx_trigger_field = rx_trigger_field_ff;
      if (wr_en && sel_trig) begin
         nxt_rx_trigger_field = pwdata[ifc_pkg::TRIG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_trigger_field_ff <= ifc_pkg::RX_TRIGGER_RST;
      end else begin
         rx_trigger_field_ff <= nxt_rx_trigger_field;
      end
   end

   // Data-available status. The fill level is one bit wider than the trigger, so a
   // completely full FIFO always counts as having reached any trigger.
   always_comb begin
      nxt_rx_avail_status = (fifo_evt.rx_level >= {1'b0, rx_trigger_field_ff});
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_avail_status_ff <= 1'b0;
      end else begin
         rx_avail_status_ff <= nxt_rx_avail_status;
      end
   end

   // Pending interrupt per status bit; only built bits can ever be pending.
   genvar gb;
   generate
      for (gb = 0; gb < ifc_pkg::DATA_W; gb++) begin : g_pend
         assign pend_bits[gb] = status_word[gb] & ~irq_mask_bits_ff[gb] & ifc_pkg::IRQ_BITS_USED[gb];
      end
   endgenerate

   // The output is registered, so it follows its cause by one cycle and never glitches.
   always_comb begin
      nxt_irq = |pend_bits;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   assign prdata = prdata_ff;
   assign rx_trigger_level = rx_trigger_field_ff;
   assign irq = irq_ff;

endmodule : ifc_irq_ctrl

// >>> bench/ifc_irq_ctrl_props.sv
`timescale 1ns/100ps
module ifc_irq_ctrl_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ifc_pkg::ADDR_W-1:0] paddr,
   input wire logic [ifc_pkg::DATA_W-1:0] pwdata,
   input wire logic [ifc_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire ifc_pkg::ifc_fifo_evt_t fifo_evt,
   input wire logic [ifc_pkg::TRIG_W-1:0] rx_trigger_level,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic ev_rx, ev_tx, setup_rd, acc, avail, mask1_ff, nxt_mask1, mw_ff, nxt_mw;
   logic [3:0] wtrig;
   assign ev_rx = fifo_evt.rx_wr & fifo_evt.rx_full;
   assign ev_tx = fifo_evt.tx_wr & fifo_evt.tx_full;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign acc = psel & penable;
   assign avail = fifo_evt.rx_level >= {1'h0, rx_trigger_level};
   assign wtrig = pwdata[3:0];
   // Tracks the receive overrun mask bit and whether the mask was ever written.
   always_comb begin
      nxt_mask1 = mask1_ff;
      nxt_mw = mw_ff;
      if (acc && pwrite && paddr == 8'h3C) begin
         nxt_mask1 = pwdata[1];
         nxt_mw = 1'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask1_ff <= 1'h1;
         mw_ff <= 1'h0;
      end else begin
         mask1_ff <= nxt_mask1;
         mw_ff <= nxt_mw;
      end
   end
   sequence s_rd(logic [7:0] a);
      setup_rd && paddr == a;
   endsequence
   sequence s_clr(logic [7:0] a, logic e);
      acc && !pwrite && paddr == a && !e ##1 setup_rd && paddr == a && !e;
   endsequence
   property p_rx_ovf; ev_rx ##1 s_rd(8'h40) |=> prdata[0]; endproperty
   property p_tx_ovf; ev_tx ##1 s_rd(8'h44) |=> prdata[0]; endproperty
   property p_rx_clr; s_clr(8'h40, ev_rx) |=> !prdata[0]; endproperty
   property p_tx_clr; s_clr(8'h44, ev_tx) |=> !prdata[0]; endproperty
   property p_stat_ovf; ev_rx ##1 s_rd(8'h38) |=> prdata[1]; endproperty
   property p_trig; acc && pwrite && paddr == 8'h48 |=> rx_trigger_level == $past(wtrig); endproperty
   property p_avail; s_rd(8'h38) |=> prdata[0] == $past(avail, 2); endproperty
   property p_irq_rx; ev_rx && !acc && !mask1_ff |-> ##2 irq; endproperty
   property p_masked; !mw_ff |-> !irq; endproperty
   a_rx_ovf: assert property (p_rx_ovf) else $error("rx overrun flag missing");
   a_tx_ovf: assert property (p_tx_ovf) else $error("tx overrun flag missing");
   a_rx_clr: assert property (p_rx_clr) else $error("rx overrun not cleared by read");
   a_tx_clr: assert property (p_tx_clr) else $error("tx overrun not cleared by read");
   a_stat_ovf: assert property (p_stat_ovf) else $error("rx overrun status missing");
   a_trig: assert property (p_trig) else $error("trigger level not written");
   a_avail: assert property (p_avail) else $error("data available status wrong");
   a_irq_rx: assert property (p_irq_rx) else $error("irq not raised");
   a_masked: assert property (p_masked) else $error("irq while masked from reset");
endmodule : ifc_irq_ctrl_props
bind ifc_irq_ctrl ifc_irq_ctrl_props i_ifc_irq_ctrl_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .fifo_evt, .rx_trigger_level, .irq);

// >>> bench/test_i2s_fifo_irq_control.sv
`timescale 1ns/100ps
module test_i2s_fifo_irq_control;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, rr;
   logic [3:0] rx_trigger_level, trig;
   ifc_pkg::ifc_fifo_evt_t fifo_evt = '0;
   int fail_count = 0, compares = 0, seed = 88, lvl = 0, k;
   always #12.5 pclk = ~pclk;
   ifc_irq_ctrl i_ifc_irq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .fifo_evt, .rx_trigger_level, .irq);
   function automatic logic [31:0] stat_exp(int l, logic [3:0] t, logic ro, logic to);
      return {26'h0, to, 3'h0, ro, 1'(l >= int'(t))};
   endfunction : stat_exp
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Leaves psel high so that a following call makes a back-to-back transfer.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      penable <= 1'h0;
   endtask : apb
   task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'h0, a, 32'h0);
      chk(n, e, rd);
   endtask : rdc
   task idle(input int n);
      psel <= 1'h0;
      repeat (n) @(posedge pclk);
   endtask : idle
   task stop_test;
      $display("Mismatches %0d comparisons %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   initial begin
      #(25 * 4000);
      fail_count++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk("trig out", 32'h3, {28'h0, rx_trigger_level});
      chk("irq", 32'h0, {31'h0, irq});
      rdc(8'h40, 32'h1, "rx ovr");
      rdc(8'h40, 32'h0, "rx ovr clr");
      rdc(8'h44, 32'h1, "tx ovr");
      rdc(8'h44, 32'h0, "tx ovr clr");
      rdc(8'h3C, 32'h23, "mask");
      rdc(8'h48, 32'h3, "trig");
      rdc(8'h4C, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, err});
      rdc(8'h38, 32'h0, "status");
      chk("no slverr", 32'h0, {31'h0, err});
      idle(1);
      for (int i = 0; i < 24; i++) begin
         rr = $random(seed);
         trig = rr[3:0];
         lvl = (i < 2) ? int'(trig) + i - 1 : int'($unsigned($random(seed)) % 17);
         if (lvl < 0) begin
            lvl = 0;
         end
         apb(1'h1, 8'h48, rr);
         fifo_evt.rx_level <= lvl[4:0];
         idle(2);
         rdc(8'h48, {28'h0, trig}, "trig");
         rdc(8'h38, stat_exp(lvl, trig, 1'h0, 1'h0), "avail");
         idle(1);
      end
      for (k = 0; k < 2; k++) begin
         // A one masks: k = 0 unmasks the receive overrun, k = 1 the transmit overrun.
         apb(1'h1, 8'h3C, k ? 32'h03 : 32'h21);
         idle(1);
         fifo_evt.rx_wr <= 1'h1;
         fifo_evt.tx_wr <= 1'h1;
         fifo_evt.rx_full <= (k == 0);
         fifo_evt.tx_full <= (k == 1);
         @(posedge pclk);
         fifo_evt.rx_wr <= 1'h0;
         fifo_evt.tx_wr <= 1'h0;
         rdc(8'h38, stat_exp(lvl, trig, k == 0, k == 1), "ovr status");
         chk("irq set", 32'h1, {31'h0, irq});
         rdc(k ? 8'h44 : 8'h40, 32'h1, "ovr flag");
         rdc(k ? 8'h44 : 8'h40, 32'h0, "ovr clr");
         rdc(k ? 8'h40 : 8'h44, 32'h0, "valid wr");
         idle(3);
         chk("irq clr", 32'h0, {31'h0, irq});
         // A second overrun read at once, in the cycle right after the event.
         fifo_evt.rx_wr <= 1'h1;
         fifo_evt.tx_wr <= 1'h1;
         @(posedge pclk);
         fifo_evt.rx_wr <= 1'h0;
         fifo_evt.tx_wr <= 1'h0;
         rdc(k ? 8'h44 : 8'h40, 32'h1, "ovr at once");
         rdc(k ? 8'h44 : 8'h40, 32'h0, "ovr at once clr");
         idle(1);
      end
      fifo_evt.rx_level <= 5'h10;
      apb(1'h1, 8'h3C, 32'h23);
      idle(3);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'h1, 8'h3C, 32'h22);
      idle(3);
      chk("irq avail", 32'h1, {31'h0, irq});
      stop_test;
   end
endmodule : test_i2s_fifo_irq_control
